// ---- xcfg_host.sv ----
// Host controller that programs the crosspoint switch over its strobe pins.
//
// Function
// - Controller repeats address and load per output to change.
// - Load and configure may share one strobe for immediate effect.
// - Reset pulse with configure low selects broadcast from input 0.
// - Reset pulse with configure high selects pass-through mapping.
// - Load stays low throughout a reset pulse.
`timescale 1ns/100ps
module xcfg_host #(
    parameter int LANES = xcfg_pkg::LANES,
    parameter int SEL_W = xcfg_pkg::SEL_W,
    parameter int DEPTH = xcfg_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Command port
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire logic [xcfg_pkg::CMD_W-1:0] i_cmd_op,
    input wire logic [SEL_W-1:0] i_cmd_output,
    input wire logic [SEL_W-1:0] i_cmd_input,
    input wire logic i_cmd_immediate,
    output logic o_busy,
    // Switch pins
    output logic [SEL_W-1:0] o_output_select_addr,
    output logic [SEL_W-1:0] o_input_select_code,
    output logic o_load,
    output logic o_configure,
    output logic o_switch_reset,
    // Host shadow of the active routing
    output logic [LANES*SEL_W-1:0] o_active_map
);
    localparam int FW = xcfg_pkg::CMD_W + 2 * SEL_W + 1;

    typedef enum logic [2:0] {
        XCFG_IDLE, XCFG_SETUP, XCFG_STROBE, XCFG_HOLD
    } xcfg_state_t;

    xcfg_state_t state_r;
    logic [xcfg_pkg::CNT_W-1:0] cnt_r;
    logic [FW-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic [xcfg_pkg::CMD_W-1:0] op_r;
    logic imm_r;
    logic [SEL_W-1:0] prog_row_r [LANES];
    logic [SEL_W-1:0] act_row_r [LANES];
    logic cfg_d_r;

    // ==========================================================
    // Command buffer
    xcfg_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_in_valid(i_cmd_valid),
        .o_in_ready(o_cmd_ready),
        .i_in_data({i_cmd_op, i_cmd_output, i_cmd_input, i_cmd_immediate}),
        .o_out_valid(fifo_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_data)
    );

    assign fifo_pop = (state_r == XCFG_IDLE);
    assign o_busy = (state_r != XCFG_IDLE) || fifo_valid;

    // ==========================================================
    // Strobe sequencer
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state_r <= XCFG_IDLE;
            cnt_r <= '0;
        end else begin
            unique case (state_r)
                XCFG_IDLE: begin
                    if (fifo_valid) begin
                        state_r <= XCFG_SETUP;
                    end
                end
                XCFG_SETUP: begin
                    state_r <= XCFG_STROBE;
                    cnt_r <= '0;
                end
                XCFG_STROBE: begin
                    if (cnt_r == xcfg_pkg::CNT_W'(xcfg_pkg::RESET_PW_CYC - 1)) begin
                        state_r <= XCFG_HOLD;
                        cnt_r <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                XCFG_HOLD: begin
                    if (cnt_r == xcfg_pkg::CNT_W'(xcfg_pkg::HOLD_CYC - 1)) begin
                        state_r <= XCFG_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Pin drivers
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            op_r <= xcfg_pkg::CMD_LOAD;
            imm_r <= 1'b0;
            o_output_select_addr <= '0;
            o_input_select_code <= '0;
            o_load <= 1'b0;
            o_configure <= 1'b0;
            o_switch_reset <= 1'b0;
        end else begin
            if (state_r == XCFG_IDLE && fifo_valid) begin
                {op_r, o_output_select_addr, o_input_select_code, imm_r} <= fifo_data;
                // configure held high before reset for pass-through
                o_configure <= (fifo_data[FW-1 -: xcfg_pkg::CMD_W] == xcfg_pkg::CMD_RESET_PASS);
            end else if (state_r == XCFG_SETUP) begin
                unique case (op_r)
                    xcfg_pkg::CMD_LOAD: begin
                        o_load <= 1'b1;
                        o_configure <= imm_r;
                    end
                    // configure strobe copies the program row
                    xcfg_pkg::CMD_CONFIGURE: o_configure <= 1'b1;
                    default: o_switch_reset <= 1'b1;
                endcase
            end else if (state_r == XCFG_STROBE &&
                         cnt_r == xcfg_pkg::CNT_W'(xcfg_pkg::RESET_PW_CYC - 1)) begin
                o_load <= 1'b0;
                o_switch_reset <= 1'b0;
                if (op_r != xcfg_pkg::CMD_RESET_PASS) begin
                    o_configure <= 1'b0;
                end
            end else if (state_r == XCFG_HOLD &&
                         cnt_r == xcfg_pkg::CNT_W'(xcfg_pkg::HOLD_CYC - 1)) begin
                o_configure <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Shadow of program and active rows
    // Configure as driven one cycle earlier, for its rising edge.
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            cfg_d_r <= 1'b0;
        end else begin
            cfg_d_r <= o_configure;
        end
    end

    for (genvar g = 0; g < LANES; g++) begin : g_lane
        always_ff @(posedge i_clk_sys or posedge i_reset) begin
            if (i_reset) begin
                prog_row_r[g] <= SEL_W'(g);
                act_row_r[g] <= SEL_W'(g);
            end else if (o_switch_reset) begin
                prog_row_r[g] <= o_configure ? SEL_W'(g) : '0;
                act_row_r[g] <= o_configure ? SEL_W'(g) : '0;
            end else begin
                // program row written per address only
                if (o_load && o_output_select_addr == SEL_W'(g)) begin
                    prog_row_r[g] <= o_input_select_code;
                end
                // active row changes only on configure
                if (o_configure && !cfg_d_r) begin
                    act_row_r[g] <= (o_load && o_output_select_addr == SEL_W'(g)) ?
                                    o_input_select_code : prog_row_r[g];
                end
            end
        end
        assign o_active_map[g*SEL_W +: SEL_W] = act_row_r[g];
    end

    // ==========================================================
    // Checks
    a_reset_load_low: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        o_switch_reset |-> !o_load) else $error("load high during reset");
    a_load_pulse_width: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $rose(o_load) |-> o_load [*1] ##1 !o_load) else $error("load width wrong");
    a_addr_hold_load: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $fell(o_load) |-> $stable(o_output_select_addr) && $stable(o_input_select_code))
        else $error("address changed at load fall");
    a_pass_cfg_held: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (o_switch_reset && op_r == xcfg_pkg::CMD_RESET_PASS) |-> o_configure)
        else $error("configure low in pass reset");
    a_bcast_cfg_low: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (o_switch_reset && op_r == xcfg_pkg::CMD_RESET_BCAST) |-> !o_configure)
        else $error("configure high in broadcast reset");
    a_cfg_after_load: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        ($rose(o_configure) && !o_switch_reset && op_r == xcfg_pkg::CMD_LOAD) |-> o_load)
        else $error("shared strobe out of step");
    a_cfg_pulse_ends: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (state_r == XCFG_SETUP && op_r == xcfg_pkg::CMD_CONFIGURE) |=>
        o_configure ##[1:3] !o_configure)
        else $error("configure pulse not ended");
    a_active_row_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (!$rose(o_configure) && !o_switch_reset) |=> $stable(o_active_map))
        else $error("active map changed without configure");

    c_load_seen: cover property (@(posedge i_clk_sys) $rose(o_load));
    c_config_seen: cover property (@(posedge i_clk_sys) $rose(o_configure) && !o_load);
    c_bcast_reset: cover property (@(posedge i_clk_sys) o_switch_reset && !o_configure);
    c_pass_reset: cover property (@(posedge i_clk_sys) o_switch_reset && o_configure);
endmodule : xcfg_host

// ---- xcfg_pkg.sv ----
// Package of constants for the crosspoint switch configuration controller.
package xcfg_pkg;
    // ==========================================================
    // Switch geometry
    localparam int LANES = 16;
    localparam int SEL_W = 4;
    localparam int CMD_W = 2;
    // ==========================================================
    // Host command codes carried with each FIFO word
    localparam logic [1:0] CMD_LOAD = 2'h0;
    localparam logic [1:0] CMD_CONFIGURE = 2'h1;
    localparam logic [1:0] CMD_RESET_BCAST = 2'h2;
    localparam logic [1:0] CMD_RESET_PASS = 2'h3;
    // ==========================================================
    // Pin timing in ns and derived cycle counts at 25 MHz
    localparam int CLK_NS = 40;
    localparam int LOAD_PW_NS = 7;
    localparam int CFG_PW_NS = 7;
    localparam int RESET_PW_NS = 10;
    localparam int HOLD_NS = 3;
    localparam int LOAD_PW_CYC = (LOAD_PW_NS + CLK_NS - 1) / CLK_NS;
    localparam int CFG_PW_CYC = (CFG_PW_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_PW_CYC = (RESET_PW_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 4;
    localparam int FIFO_DEPTH = 4;
endpackage : xcfg_pkg

// ---- xcfg_fifo.sv ----
// Parameterised valid/ready FIFO for host commands.
`timescale 1ns/100ps
module xcfg_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign o_in_ready = (count_r != (AW+1)'(DEPTH));
    assign o_out_valid = (count_r != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem[rd_ptr_r];

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem[wr_ptr_r] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_no_overflow: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        count_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : xcfg_fifo

// ---- xcfg_switch_model.sv ----
// Behavioural model of the switch's two rows of routing latches.
`timescale 1ns/100ps
module xcfg_switch_model (
    // Control pins
    input wire logic [3:0] i_output_select_addr,
    input wire logic [3:0] i_input_select_code,
    input wire logic i_load,
    input wire logic i_configure,
    input wire logic i_switch_reset,
    // Active routing and pin misuse flag
    output logic [63:0] o_active_map,
    output logic o_pin_err
);
    logic [3:0] program_latch_row [16];
    logic [3:0] active_latch_row [16];
    initial o_pin_err = 1'b0;
    // ==========================================================
    // Latch rows
    // binary load capture
    always @(posedge i_load) program_latch_row[i_output_select_addr] = i_input_select_code;
    always @(posedge i_configure) begin
        // A load rising in the same step must land before the copy.
        #1;
        active_latch_row = program_latch_row;
    end
    always @(posedge i_switch_reset) begin
        for (int g = 0; g < 16; g++) begin
            program_latch_row[g] = i_configure ? 4'(g) : 4'h0;
            active_latch_row[g] = program_latch_row[g];
        end
    end
    always_comb begin
        for (int g = 0; g < 16; g++) o_active_map[4*g +: 4] = active_latch_row[g];
    end
    // ==========================================================
    // Pin misuse
    // load low in reset
    always @(posedge i_switch_reset or posedge i_load) begin
        if (i_load && i_switch_reset) o_pin_err = 1'b1;
    end
    always @(i_output_select_addr or i_input_select_code) begin
        if (i_load) o_pin_err = 1'b1;
    end
endmodule : xcfg_switch_model

// ---- xcfg_host_test.sv ----
// Self-checking testbench for the crosspoint switch host controller.
`timescale 1ns/100ps
module xcfg_host_test;
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic i_cmd_valid = 1'b0;
    logic i_cmd_immediate = 1'b0;
    logic [1:0] i_cmd_op = 2'h0;
    logic [3:0] i_cmd_output = 4'h0;
    logic [3:0] i_cmd_input = 4'h0;
    logic o_cmd_ready, o_busy, o_load, o_configure, o_switch_reset, pin_err;
    logic strobe_q = 1'b0;
    logic [3:0] o_output_select_addr, o_input_select_code;
    logic [63:0] o_active_map, sw_map;
    logic [3:0] prog [16];
    logic [3:0] act [16];
    logic [63:0] exp_q [$];
    int n_fail = 0;
    int num_checks = 0;
    int n_refused = 0;
    always #20 i_clk_sys = ~i_clk_sys;
    xcfg_host DUT (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid),
        .o_cmd_ready(o_cmd_ready), .i_cmd_op(i_cmd_op), .i_cmd_output(i_cmd_output),
        .i_cmd_input(i_cmd_input), .i_cmd_immediate(i_cmd_immediate), .o_busy(o_busy),
        .o_output_select_addr(o_output_select_addr),
        .o_input_select_code(o_input_select_code), .o_load(o_load),
        .o_configure(o_configure), .o_switch_reset(o_switch_reset),
        .o_active_map(o_active_map));
    xcfg_switch_model SW (.i_output_select_addr(o_output_select_addr),
        .i_input_select_code(o_input_select_code), .i_load(o_load),
        .i_configure(o_configure), .i_switch_reset(o_switch_reset),
        .o_active_map(sw_map), .o_pin_err(pin_err));
    // ==========================================================
    // Checking helpers
    task automatic check(input logic [63:0] got, input logic [63:0] want);
        num_checks++;
        if (got !== want) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : check
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    function automatic logic [63:0] packed_map();
        logic [63:0] m;
        for (int g = 0; g < 16; g++) m[4*g +: 4] = act[g];
        return m;
    endfunction : packed_map
    // ==========================================================
    // Command driver
    task automatic send(input logic [1:0] op, input logic [3:0] o, input logic [3:0] i,
                        input logic imm);
        logic rdy;
        i_cmd_valid <= 1'b1;
        i_cmd_op <= op;
        i_cmd_output <= o;
        i_cmd_input <= i;
        i_cmd_immediate <= imm;
        forever begin
            @(negedge i_clk_sys);
            rdy = o_cmd_ready;
            @(posedge i_clk_sys);
            if (rdy === 1'b1) break;
            n_refused++;
        end
        if (op == xcfg_pkg::CMD_LOAD) prog[o] = i;
        for (int g = 0; g < 16; g++) begin
            if (op == xcfg_pkg::CMD_RESET_BCAST) prog[g] = 4'h0;
            if (op == xcfg_pkg::CMD_RESET_PASS) prog[g] = 4'(g);
        end
        if (op != xcfg_pkg::CMD_LOAD || imm) begin
            act = prog;
            exp_q.push_back(packed_map());
        end
    endtask : send
    task automatic drain;
        i_cmd_valid <= 1'b0;
        repeat (200) begin
            @(negedge i_clk_sys);
            if (o_busy === 1'b0) break;
        end
        check(64'(o_busy), 64'h0);
        @(posedge i_clk_sys);
    endtask : drain
    // ==========================================================
    // Result monitor: one result per fall of configure or reset
    always @(negedge i_clk_sys) begin
        strobe_q <= o_configure | o_switch_reset;
        if (strobe_q && !(o_configure | o_switch_reset)) begin
            if (exp_q.size() == 0) begin
                check(64'(exp_q.size()), 64'h1);
            end else begin
                check(sw_map, exp_q[0]);
                check(o_active_map, exp_q.pop_front());
            end
        end
    end
    initial begin
        #(40 * 4000);
        n_fail++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h4C28F4E0));
        repeat (5) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        @(posedge i_clk_sys);
        check(o_active_map, 64'hFEDCBA9876543210);
        send(xcfg_pkg::CMD_RESET_PASS, 4'h0, 4'h0, 1'b0);
        drain();
        send(xcfg_pkg::CMD_RESET_BCAST, 4'h0, 4'h0, 1'b0);
        drain();
        send(xcfg_pkg::CMD_LOAD, 4'hF, 4'hF, 1'b0);
        send(xcfg_pkg::CMD_LOAD, 4'h0, 4'hF, 1'b0);
        send(xcfg_pkg::CMD_LOAD, 4'h7, 4'h1, 1'b0);
        drain();
        check(sw_map, packed_map());
        check(o_active_map, packed_map());
        send(xcfg_pkg::CMD_CONFIGURE, 4'h0, 4'h0, 1'b0);
        send(xcfg_pkg::CMD_LOAD, 4'h3, 4'h9, 1'b1);
        send(xcfg_pkg::CMD_LOAD, 4'h4, 4'h9, 1'b1);
        drain();
        for (int k = 0; k < 16; k++) begin
            send(xcfg_pkg::CMD_LOAD, 4'(k), 4'($urandom_range(15)), 1'b0);
        end
        send(xcfg_pkg::CMD_CONFIGURE, 4'h0, 4'h0, 1'b0);
        drain();
        check(64'(n_refused > 0), 64'h1);
        check(64'(pin_err), 64'h0);
        check(64'(exp_q.size()), 64'h0);
        stop_test();
    end
endmodule : xcfg_host_test
